// ---- shared/ehm_cfg.svh ----
// constants for the event and hour meter core
// Summary of operation
// [R1] Four mode pins form a binary mode number from zero to fifteen.
// [R2] Modes 0-3 time at 1 h, 0.1 h, 0.01 h and 0.1 min steps.
// [R3] Modes 4-11 count pulses per 1, 10, 100, 1000; even modes debounce.
// [R4] Crystal divided into 1 s, 6 s, 36 s ticks and 32 Hz drive.
// [R5] Backplane toggles every 512 crystal cycles, giving 32 Hz.
// [R6] Segments toggle with backplane: in phase is off, antiphase is on.
// [R7] Timing active while start/stop held high or toggling 50 Hz to 120 kHz.
// [R8] Source must avoid toggling start/stop between 40 Hz and 50 Hz.
// [R9] Only low periods of start/stop are interval qualified; a steady high never times out.
// [R10] Counter modes count each filtered rising edge of start/stop.
// [R11] Debounced modes count slow pulses singly, a long fast burst once.
// [R12] Non-debounced modes count every start/stop pulse up to 120 kHz.
// [R13] Timer wink: off 16, on 16 cycles while active; steady on otherwise.
// [R14] Counter wink: off after 16th cycle, on after 32nd, on each count.
// [R15] Counts faster than once a second keep wink flashing at 1 Hz.
// [R16] Display test: 16 cycles all on, 48 all off, then normal data.
// [R17] Display test held high keeps all segments on.
// [R18] Mode 12 increments every displayed decade on each start/stop rise.
// [R19] Modes 13 and 14 are factory test only, not for normal use.
// [R20] Mode 15 clears all decades, prescalers and dividers to zero.
// [R21] Three prescale decades feed five and a half BCD display decades.
// [R22] Power-up clears the displayed count to zero without a reset pin; the core clears it on i_rstn instead.
// [R23] Display decades wrap to zero past the largest showable value.
`ifndef EHM_CFG_SVH
`define EHM_CFG_SVH
`define EHM_CLK_MHZ     20
`define EHM_HP_US       12500
`define EHM_HP_CYC      (`EHM_HP_US * `EHM_CLK_MHZ)
`define EHM_SEC_MAX     15'h7FFF
`define EHM_BP_BIT      9
`define EHM_BP_HALF_M1  9'h01FF
`define EHM_BP_RISE_AT  10'h01FF
`define EHM_DIV6_MAX    3'h5
`define EHM_BCD_MAX     4'h9
`define EHM_WINK_END    5'h1F
`define EHM_TST_ON      6'h10
`define EHM_TST_END     6'h3F
`define EHM_PRE_N       3
`define EHM_DISP_N      5
`endif

// ---- shared/ehm_pkg.sv ----
// types for the event and hour meter core
package ehm_pkg;
  typedef enum logic [3:0] {
    EHM_M_HR      = 4'h0,
    EHM_M_HR10    = 4'h1,
    EHM_M_HR100   = 4'h2,
    EHM_M_MIN10   = 4'h3,
    EHM_M_C1D     = 4'h4,
    EHM_M_C1      = 4'h5,
    EHM_M_C10D    = 4'h6,
    EHM_M_C10     = 4'h7,
    EHM_M_C100D   = 4'h8,
    EHM_M_C100    = 4'h9,
    EHM_M_C1KD    = 4'hA,
    EHM_M_C1K     = 4'hB,
    EHM_M_DIGTEST = 4'hC,
    EHM_M_FT0     = 4'hD,
    EHM_M_FT1     = 4'hE,
    EHM_M_CLEAR   = 4'hF
  } ehm_mode_t;
  typedef logic [3:0] ehm_bcd_t;
  typedef logic [6:0] ehm_seg7_t;
endpackage

// ---- shared/ehm_seg_if.sv ----
// carrier between a display decade and its segment decoder
`timescale 1ns/10ps
interface ehm_seg_if;
  ehm_pkg::ehm_bcd_t  bcd;
  ehm_pkg::ehm_seg7_t seg;
  modport src (output bcd, input seg);
  modport dec (input bcd, output seg);
endinterface

// ---- verilog/ehm_seg_dec.sv ----
// bcd to seven-segment decoder, bit 0 is segment a
`timescale 1ns/10ps
module ehm_seg_dec #(
  parameter bit BLANK_BAD = 1'b1
) (
  ehm_seg_if.dec sif
);
  always_comb begin
    case (sif.bcd)
      4'h0:    sif.seg = 7'h3F;
      4'h1:    sif.seg = 7'h06;
      4'h2:    sif.seg = 7'h5B;
      4'h3:    sif.seg = 7'h4F;
      4'h4:    sif.seg = 7'h66;
      4'h5:    sif.seg = 7'h6D;
      4'h6:    sif.seg = 7'h7D;
      4'h7:    sif.seg = 7'h07;
      4'h8:    sif.seg = 7'h7F;
      4'h9:    sif.seg = 7'h6F;
      // codes above nine never occur; dash when not blanked
      default: sif.seg = BLANK_BAD ? 7'h00 : 7'h40;
    endcase
  end
endmodule // ehm_seg_dec

// ---- verilog/ehm_core.sv ----
// event counter and hour meter core with static lcd drive
`timescale 1ns/10ps
`include "ehm_cfg.svh"
module ehm_core #(
  parameter int HP_CYC = `EHM_HP_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_xtal_in,
  input  wire logic        i_start_stop,
  input  wire logic        i_display_test_in,
  input  wire logic        i_mode_sel_bit0,
  input  wire logic        i_mode_sel_bit1,
  input  wire logic        i_mode_sel_bit2,
  input  wire logic        i_mode_sel_bit3,
  output logic             o_xtal_out,
  output logic             o_lcd_backplane,
  output logic [34:0]      o_seg,
  output logic             o_half_digit_segment,
  output logic             o_wink
);
  localparam int HPW = $clog2(HP_CYC + 1);
  localparam logic [HPW-1:0] HP_MAX = HPW'(HP_CYC - 1);
  localparam int NST = `EHM_PRE_N + `EHM_DISP_N;

  // input synchronisers; s3 only serves edge detection of s2
  logic [6:0] s1_q, s2_q, s3_q, s1_d;
  assign s1_d = {i_mode_sel_bit3, i_mode_sel_bit2, i_mode_sel_bit1, i_mode_sel_bit0,
                 i_display_test_in, i_start_stop, i_xtal_in};
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {s1_q, s2_q, s3_q} <= '0;
    end else begin
      {s1_q, s2_q, s3_q} <= {s1_d, s1_q, s2_q};
    end
  end

  ehm_pkg::ehm_mode_t mode;
  logic xt_tick, ss, ss_rise, ss_edge, dt, dt_rise;
  logic timer, ctr, deb, clr;
  assign mode    = ehm_pkg::ehm_mode_t'(s2_q[6:3]); // R1
  assign xt_tick = s2_q[0] & ~s3_q[0];
  assign ss      = s2_q[1];
  assign ss_rise = s2_q[1] & ~s3_q[1];
  assign ss_edge = s2_q[1] ^ s3_q[1];
  assign dt      = s2_q[2];
  assign dt_rise = s2_q[2] & ~s3_q[2];
  assign timer   = (mode <= ehm_pkg::EHM_M_MIN10);
  assign ctr     = (mode >= ehm_pkg::EHM_M_C1D) && (mode <= ehm_pkg::EHM_M_C1K);
  assign deb     = ctr & ~mode[0]; // R3
  assign clr     = (mode == ehm_pkg::EHM_M_CLEAR);

  // timebase: one crystal counter gives backplane and seconds
  logic [14:0] xdiv_q, xdiv_d;
  logic [2:0]  d6a_q, d6a_d, d6b_q, d6b_d;
  logic        sec_tick, t6, t36, bp, bp_rise;
  assign sec_tick = xt_tick && (xdiv_q == `EHM_SEC_MAX);
  assign t6       = sec_tick && (d6a_q == `EHM_DIV6_MAX);
  assign t36      = t6 && (d6b_q == `EHM_DIV6_MAX); // R4
  assign bp       = xdiv_q[`EHM_BP_BIT]; // R5
  assign bp_rise  = xt_tick && (xdiv_q[9:0] == `EHM_BP_RISE_AT);
  always_comb begin
    xdiv_d = xdiv_q;
    d6a_d  = d6a_q;
    d6b_d  = d6b_q;
    if (clr) begin
      xdiv_d = '0; // R20
      d6a_d  = '0;
      d6b_d  = '0;
    end else if (xt_tick) begin
      xdiv_d = xdiv_q + 15'h0001; // R5
      if (sec_tick) begin
        d6a_d = (d6a_q == `EHM_DIV6_MAX) ? 3'h0 : d6a_q + 3'h1; // R4
        if (t6) begin
          d6b_d = (d6b_q == `EHM_DIV6_MAX) ? 3'h0 : d6b_q + 3'h1;
        end
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {xdiv_q, d6a_q, d6b_q} <= '0;
    end else begin
      {xdiv_q, d6a_q, d6b_q} <= {xdiv_d, d6a_d, d6b_d};
    end
  end

  // high-pass qualifier: any edge arms, a long quiet low disarms
  logic [HPW-1:0] hp_cnt_q, hp_cnt_d;
  logic           active_q, active_d, act_p_q, act_rise;
  assign act_rise = active_q & ~act_p_q;
  always_comb begin
    hp_cnt_d = hp_cnt_q;
    active_d = active_q;
    if (clr) begin
      hp_cnt_d = '0;
      active_d = 1'b0;
    end else if (ss_edge) begin
      hp_cnt_d = '0; // R7
      active_d = 1'b1;
    end else if (hp_cnt_q != HP_MAX) begin
      hp_cnt_d = hp_cnt_q + 1'b1;
    end else if (!ss) begin
      active_d = 1'b0; // R9
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {hp_cnt_q, active_q, act_p_q} <= '0;
    end else begin
      {hp_cnt_q, active_q, act_p_q} <= {hp_cnt_d, active_d, active_q};
    end
  end

  // event source and where it enters the decade chain
  logic       cnt_ev, tb_ev, ev;
  logic [1:0] pt;
  // a fast burst holds the qualifier high, so it yields one rise
  assign cnt_ev = ctr && (deb ? act_rise : ss_rise); // R10 R11 R12
  assign tb_ev  = (mode == ehm_pkg::EHM_M_MIN10) ? t6 : t36;
  assign ev     = timer ? (tb_ev & active_q) : cnt_ev; // R2 R7
  always_comb begin
    case (mode)
      ehm_pkg::EHM_M_HR,    ehm_pkg::EHM_M_C100D, ehm_pkg::EHM_M_C100: pt = 2'h1;
      ehm_pkg::EHM_M_HR10,  ehm_pkg::EHM_M_C10D,  ehm_pkg::EHM_M_C10:  pt = 2'h2;
      ehm_pkg::EHM_M_C1KD,  ehm_pkg::EHM_M_C1K:                        pt = 2'h0;
      default:                                                         pt = 2'h3;
    endcase
  end

  // decade chain: stages 0-2 prescale, 3-7 display, plus half digit
  logic [NST-1:0][3:0] dig_q, dig_d;
  logic                half_q, half_d;
  logic                carry, cin;
  always_comb begin
    dig_d  = dig_q;
    half_d = half_q;
    carry  = 1'b0;
    cin    = 1'b0;
    if (clr) begin
      dig_d  = '0; // R20
      half_d = 1'b0;
    end else if (mode == ehm_pkg::EHM_M_DIGTEST) begin
      if (ss_rise) begin
        for (int i = `EHM_PRE_N; i < NST; i++) begin
          dig_d[i] = (dig_q[i] == `EHM_BCD_MAX) ? 4'h0 : dig_q[i] + 4'h1; // R18
        end
        half_d = ~half_q;
      end
    end else begin
      for (int i = 0; i < NST; i++) begin
        cin = carry | (ev && (i == int'(pt))); // R21
        if (cin) begin
          dig_d[i] = (dig_q[i] == `EHM_BCD_MAX) ? 4'h0 : dig_q[i] + 4'h1;
        end
        carry = cin && (dig_q[i] == `EHM_BCD_MAX);
      end
      if (carry) begin
        half_d = ~half_q; // R23
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {dig_q, half_q} <= '0; // R22
    end else begin
      {dig_q, half_q} <= {dig_d, half_d};
    end
  end

  // wink: bp-cycle counter; bit 4 marks the second half-second
  logic [4:0] wk_cnt_q, wk_cnt_d;
  logic       wk_run_q, wk_run_d, wk_pend_q, wk_pend_d;
  logic       wk_start, wk_wrap, wk_more, wink_off;
  assign wk_start = !wk_run_q && (timer ? ss_rise : cnt_ev);
  assign wk_wrap  = wk_run_q && bp_rise && (wk_cnt_q == `EHM_WINK_END);
  assign wk_more  = timer ? active_q : wk_pend_q;
  assign wink_off = wk_run_q && (wk_cnt_q[4] ^ timer); // R13 R14
  always_comb begin
    wk_cnt_d  = wk_cnt_q;
    wk_run_d  = wk_run_q;
    // a count landing on the wrap cycle is kept for the next flash
    wk_pend_d = (wk_pend_q & ~wk_wrap) | (cnt_ev & wk_run_q); // R15
    if (clr) begin
      wk_cnt_d  = '0;
      wk_run_d  = 1'b0;
      wk_pend_d = 1'b0;
    end else if (wk_start) begin
      wk_cnt_d = '0;
      wk_run_d = 1'b1;
    end else if (wk_run_q && bp_rise) begin
      wk_cnt_d = wk_cnt_q + 5'h01;
      if (wk_wrap && !wk_more) begin
        wk_run_d = 1'b0; // R13 R15
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {wk_cnt_q, wk_run_q, wk_pend_q} <= '0;
    end else begin
      {wk_cnt_q, wk_run_q, wk_pend_q} <= {wk_cnt_d, wk_run_d, wk_pend_d};
    end
  end

  // display test sequencer, independent of counting
  logic [5:0] tst_cnt_q, tst_cnt_d;
  logic       tst_arm_q, tst_arm_d, tst_run_q, tst_run_d;
  always_comb begin
    tst_cnt_d = tst_cnt_q;
    tst_run_d = tst_run_q;
    tst_arm_d = tst_arm_q;
    if (bp_rise && tst_arm_q) begin
      tst_run_d = 1'b1; // R16
      tst_cnt_d = '0;
      tst_arm_d = 1'b0;
    end else if (bp_rise && tst_run_q) begin
      tst_cnt_d = tst_cnt_q + 6'h01;
      if (tst_cnt_q == `EHM_TST_END) begin
        tst_run_d = 1'b0;
      end
    end
    if (dt_rise) begin
      tst_arm_d = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {tst_cnt_q, tst_run_q, tst_arm_q} <= '0;
    end else begin
      {tst_cnt_q, tst_run_q, tst_arm_q} <= {tst_cnt_d, tst_run_d, tst_arm_d};
    end
  end

  // segment decode per display decade
  logic [34:0] seg_norm, seg_on;
  logic        all_on, all_off, half_on;
  for (genvar g = 0; g < `EHM_DISP_N; g++) begin : g_dig
    ehm_seg_if u_sif ();
    assign u_sif.bcd = dig_q[g + `EHM_PRE_N];
    ehm_seg_dec #(.BLANK_BAD(1'b1)) u_dec (.sif(u_sif.dec));
    assign seg_norm[g*7 +: 7] = u_sif.seg;
  end
  assign all_on  = dt || (tst_run_q && (tst_cnt_q < `EHM_TST_ON)); // R16 R17
  assign all_off = !dt && tst_run_q && (tst_cnt_q >= `EHM_TST_ON); // R16
  assign seg_on  = all_on ? '1 : (all_off ? '0 : seg_norm);
  assign half_on = all_on | (half_q & ~all_off);

  // output stage: each segment, half digit and wink drive is the backplane xor its on state
  logic [34:0] o_seg_d;
  logic        o_bp_d, o_half_d, o_wink_d, o_xo_d;
  always_comb begin
    o_bp_d   = bp;
    o_seg_d  = {35{bp}} ^ seg_on; // R6
    o_half_d = bp ^ half_on;
    o_wink_d = bp ^ ~wink_off;
    o_xo_d   = ~s2_q[0];
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      {o_lcd_backplane, o_seg, o_half_digit_segment, o_wink, o_xtal_out} <= '0;
    end else begin
      {o_lcd_backplane, o_seg, o_half_digit_segment} <= {o_bp_d, o_seg_d, o_half_d};
      {o_wink, o_xtal_out} <= {o_wink_d, o_xo_d};
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_tst_go;
    bp_rise && tst_arm_q;
  endsequence
  sequence s_wink_go;
    ctr && cnt_ev && !wk_run_q;
  endsequence
  property p_bp_hold;
    xt_tick && !clr && (xdiv_q[8:0] != `EHM_BP_HALF_M1) |=> $stable(bp);
  endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("backplane moved early"); // R5
  property p_bp_tog;
    xt_tick && !clr && (xdiv_q[8:0] == `EHM_BP_HALF_M1) |=> $changed(bp);
  endproperty
  a_bp_tog: assert property (p_bp_tog) else $error("backplane missed toggle"); // R5
  property p_phase;
    1'b1 |=> (o_seg == ({35{$past(bp)}} ^ $past(seg_on))) && (o_lcd_backplane == $past(bp));
  endproperty
  a_phase: assert property (p_phase) else $error("segment phase wrong"); // R6
  property p_clear;
    clr |=> (xdiv_q == '0) && (dig_q == '0) && !half_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear mode left state"); // R20
  property p_hour;
    timer && ss_rise && !t6 |=> dig_q == $past(dig_q);
  endproperty
  a_hour: assert property (p_hour) else $error("timer counted a pulse"); // R2
  property p_nodeb;
    (mode == ehm_pkg::EHM_M_C1) && ss_rise |=> dig_q != $past(dig_q);
  endproperty
  a_nodeb: assert property (p_nodeb) else $error("raw pulse not counted"); // R12
  property p_deb;
    (mode == ehm_pkg::EHM_M_C1D) && ss_rise && act_p_q |=> dig_q == $past(dig_q);
  endproperty
  a_deb: assert property (p_deb) else $error("burst pulse counted again"); // R11
  property p_wink_tmr;
    timer && ss_rise && !wk_run_q |=> wink_off;
  endproperty
  a_wink_tmr: assert property (p_wink_tmr) else $error("timer wink did not go off"); // R13
  property p_wink_go;
    s_wink_go |=> wk_run_q && (wk_cnt_q == 5'h00) && !wink_off;
  endproperty
  a_wink_go: assert property (p_wink_go) else $error("counter wink start wrong"); // R14
  property p_tst_go;
    s_tst_go |=> tst_run_q && (tst_cnt_q == 6'h00) && (&seg_on);
  endproperty
  a_tst_go: assert property (p_tst_go) else $error("display test did not start"); // R16
  property p_tst_off;
    tst_run_q && !dt && (tst_cnt_q >= `EHM_TST_ON) |-> (seg_on == '0) && !half_on;
  endproperty
  a_tst_off: assert property (p_tst_off) else $error("test blank phase wrong"); // R16
  property p_dt_hold;
    dt |-> (&seg_on) && half_on;
  endproperty
  a_dt_hold: assert property (p_dt_hold) else $error("held test not all on"); // R17
  property p_m12;
    (mode == ehm_pkg::EHM_M_DIGTEST) && ss_rise |=>
      (dig_q[3] == (($past(dig_q[3]) == `EHM_BCD_MAX) ? 4'h0 : $past(dig_q[3]) + 4'h1))
      && (half_q != $past(half_q));
  endproperty
  a_m12: assert property (p_m12) else $error("digit test step wrong"); // R18
  property p_wrap;
    (mode == ehm_pkg::EHM_M_C1) && ev && half_q && (dig_q[7:3] == {5{`EHM_BCD_MAX}})
      |=> (dig_q[7:3] == '0) && !half_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("display did not wrap"); // R23
endmodule // ehm_core

// ---- testbench/ehm_lcd_src.sv ----
// partner model: crystal and start/stop source plus a static lcd panel
`timescale 1ns/10ps
module ehm_lcd_src #(
  parameter int XH = 2
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_bp,
  input  wire logic [34:0] i_seg,
  input  wire logic        i_half,
  input  wire logic        i_wink,
  output logic             o_xtal,
  output logic             o_start_stop,
  output logic [34:0]      o_lit,
  output logic             o_lit_half,
  output logic             o_lit_wink
);
  int xcnt = 0;
  // a segment is lit only when driven against the backplane
  assign o_lit      = i_seg ^ {35{i_bp}};
  assign o_lit_half = i_half ^ i_bp;
  assign o_lit_wink = i_wink ^ i_bp;
  initial begin
    o_xtal       = 1'b0;
    o_start_stop = 1'b0;
  end
  // crystal sped up so that backplane periods fit the run
  always @(posedge i_sys_clk) begin
    #2;
    xcnt = (xcnt + 1) % XH;
    if (xcnt == 0) begin
      o_xtal = ~o_xtal;
    end
  end
  // widths of two clocks or more, far from the undefined band
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge i_sys_clk);
      #2 o_start_stop = 1'b1;
      repeat (hi) @(posedge i_sys_clk);
      #2 o_start_stop = 1'b0;
      repeat (lo - 1) @(posedge i_sys_clk);
    end
  endtask
endmodule // ehm_lcd_src

// ---- testbench/test_ehm_core.sv ----
// self-checking bench for the event and hour meter core
`timescale 1ns/10ps
module test_ehm_core;
  localparam int HP = 200;
  localparam int XH = 2;
  localparam logic [34:0] ALL_ON = 35'h7_ffff_ffff;
  localparam logic [6:0] SEGS [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                       7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic        dt        = 1'b0;
  logic [3:0]  mode      = 4'h0;
  logic        xtal;
  logic        xo;
  logic        ss;
  logic        bp;
  logic        half;
  logic        wink;
  logic [34:0] seg;
  logic [34:0] lit;
  logic        lit_half;
  logic        lit_wink;
  int          fails     = 0;
  int          cmp_count = 0;
  int          seed      = 32'hb9e9;
  int          n;
  int          k;
  int          m;

  always #25 clk = ~clk;

  ehm_core #(.HP_CYC(HP)) dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_xtal_in(xtal), .i_start_stop(ss),
    .i_display_test_in(dt), .i_mode_sel_bit0(mode[0]), .i_mode_sel_bit1(mode[1]),
    .i_mode_sel_bit2(mode[2]), .i_mode_sel_bit3(mode[3]), .o_xtal_out(xo),
    .o_lcd_backplane(bp), .o_seg(seg), .o_half_digit_segment(half), .o_wink(wink)
  );
  ehm_lcd_src #(.XH(XH)) src (
    .i_sys_clk(clk), .i_bp(bp), .i_seg(seg), .i_half(half), .i_wink(wink),
    .o_xtal(xtal), .o_start_stop(ss), .o_lit(lit), .o_lit_half(lit_half),
    .o_lit_wink(lit_wink)
  );

  function automatic logic [34:0] lit_of(input int v);
    logic [34:0] r;
    r = '0;
    for (int g = 0; g < 5; g++) begin
      r[g*7 +: 7] = SEGS[(v / (10 ** g)) % 10];
    end
    return r;
  endfunction

  task automatic cmp_vec(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_disp(input int v, input logic h);
    cmp_vec(lit, lit_of(v));
    cmp_bit(lit_half, h);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #2;
  endtask

  task automatic set_mode(input logic [3:0] md);
    @(posedge clk);
    #2 mode = md;
    repeat (6) @(posedge clk);
  endtask

  // counts clocks until the backplane reaches the given level
  task automatic wait_bp(input logic v, output int c);
    c = 0;
    while (bp !== v && c < 3000) begin
      @(posedge clk);
      #2;
      c++;
    end
    if (bp !== v) begin
      fails++;
      results();
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    settle();
    chk_disp(0, 1'b0);
    cmp_bit(lit_wink, 1'b1);
    m = int'(xo);
    repeat (2) @(posedge clk);
    #2 cmp_bit(xo, ~1'(m));
    $display("test reset done");
    wait_bp(1'b0, n);
    wait_bp(1'b1, n);
    wait_bp(1'b0, n);
    cmp_vec(35'(n), 35'(512 * 2 * XH));
    $display("test backplane done");
    // per-1, per-10, per-100, per-1000 counters, prescalers cleared between
    for (int i = 0; i < 4; i++) begin
      m = 5 + 2 * i;
      k = 10 ** i;
      set_mode(ehm_pkg::EHM_M_CLEAR);
      set_mode(4'(m));
      src.pulses(k - 1, 2, 2);
      settle();
      chk_disp(0, 1'b0);
      set_mode(ehm_pkg::EHM_M_CLEAR);
      set_mode(4'(m));
      src.pulses(k - 1, 2, 2);
      settle();
      chk_disp(0, 1'b0);
      src.pulses(1, 2, 2);
      settle();
      chk_disp(1, 1'b0);
    end
    $display("test counter modes done");
    set_mode(ehm_pkg::EHM_M_C1);
    n = 1 + $unsigned($random(seed)) % 40;
    for (int j = 0; j < n; j++) begin
      src.pulses(1, 2 + $unsigned($random(seed)) % 3, 2 + $unsigned($random(seed)) % 3);
    end
    settle();
    chk_disp(1 + n, 1'b0);
    set_mode(ehm_pkg::EHM_M_CLEAR);
    settle();
    chk_disp(0, 1'b0);
    $display("test random count done");
    set_mode(ehm_pkg::EHM_M_DIGTEST);
    k = 1 + $unsigned($random(seed)) % 25;
    src.pulses(k, 3, 3);
    settle();
    chk_disp((k % 10) * 11111, 1'(k & 1));
    $display("test digit mode done");
    set_mode(ehm_pkg::EHM_M_CLEAR);
    set_mode(ehm_pkg::EHM_M_C1D);
    src.pulses(5 + $unsigned($random(seed)) % 20, 3, 3);
    repeat (HP + 20) @(posedge clk);
    src.pulses(1, 3, 3);
    repeat (HP + 20) @(posedge clk);
    settle();
    chk_disp(2, 1'b0);
    $display("test debounce done");
    // random timer mode: a rise starts the wink but never counts
    set_mode(ehm_pkg::EHM_M_CLEAR);
    set_mode(4'($unsigned($random(seed)) % 4));
    settle();
    cmp_bit(lit_wink, 1'b1);
    src.pulses(1, 3, 3);
    settle();
    cmp_bit(lit_wink, 1'b0);
    chk_disp(0, 1'b0);
    $display("test timer wink done");
    // level test first, far from a backplane rise so the sequencer is idle
    wait_bp(1'b0, n);
    @(posedge clk);
    #2 dt = 1'b1;
    settle();
    cmp_vec(lit, ALL_ON);
    @(posedge clk);
    #2 rstn = 1'b0;
    dt = 1'b0;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    settle();
    chk_disp(0, 1'b0);
    wait_bp(1'b0, n);
    @(posedge clk);
    #2 dt = 1'b1;
    repeat (3) @(posedge clk);
    #2 dt = 1'b0;
    settle();
    chk_disp(0, 1'b0);
    wait_bp(1'b1, n);
    settle();
    cmp_vec(lit, ALL_ON);
    cmp_bit(lit_half, 1'b1);
    $display("test display test done");
    results();
  end
endmodule // test_ehm_core
